// File: design/tsq_clause_eval.sv
/*
  Combinational evaluator of one if-then clause: selects its events,
  joins them left to right and applies the negation.
  Assumes the sequencer supplies registered program and sampled events.
*/
`timescale 1ns/1ps
module tsq_clause_eval (
  // Clause link
  tsq_clause_if.eval cl
);
  always_comb begin
    logic acc;
    logic ev_i;
    acc = cl.ev[cl.cfg.ev_sel[0]];
    ev_i = 1'b0;
    for (int i = 1; i < tsq_pkg::EV_N; i++) begin
      if (tsq_pkg::EV_CNT_W'(i) < cl.cfg.ev_cnt) begin
        ev_i = cl.ev[cl.cfg.ev_sel[i]];
        acc = cl.cfg.join_or[i-1] ? (acc | ev_i) : (acc & ev_i);
      end
    end
    // Empty clause never fires, negated or not
    cl.hit = (cl.cfg.ev_cnt != '0) && (acc ^ cl.cfg.negate);
  end
endmodule

// File: design/tsq_trigger_seq.sv
/*
  Trigger state sequencer: evaluates the clauses of the active trigger
  state on every qualified sample, places the trigger, qualifies storage
  and drives a marker output, with a small register port and interrupt.
  Assumes samples arrive on sys_clk already qualified by the clock
  equation, and acquisition memory accepts one write per cycle.
*/
`timescale 1ns/1ps
module tsq_trigger_seq #(
  parameter int NUM_STATES = 16,
  parameter int NUM_CLAUSES = 8,
  parameter int NUM_WORDS = 4,
  parameter int DATA_W = 32,
  parameter int MEM_DEPTH = 8192
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [tsq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tsq_pkg::REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tsq_pkg::REG_W-1:0] reg_rdata,
  // Sample stream
  input wire logic samp_valid,
  input wire logic [DATA_W-1:0] samp_data,
  // Acquisition memory
  output logic mem_wr,
  output logic [$clog2(MEM_DEPTH)-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_data,
  output logic mem_trig,
  output logic mem_stop,
  // Status
  output logic acq_active,
  output logic marker_out,
  output logic irq
);
  localparam int AW = $clog2(MEM_DEPTH);
  localparam int CW = $clog2(MEM_DEPTH + 1);
  localparam int SW = tsq_pkg::ST_IDX_W;
  localparam int CLW = tsq_pkg::CL_IDX_W;

  if (NUM_STATES < 1 || NUM_STATES > (1 << SW) || NUM_CLAUSES < 1 ||
      NUM_CLAUSES > (1 << CLW) || NUM_WORDS < 1 || NUM_WORDS > 4 ||
      DATA_W < 1 || DATA_W > tsq_pkg::REG_W || MEM_DEPTH < 8 ||
      (MEM_DEPTH & (MEM_DEPTH - 1)) != 0 || CW > tsq_pkg::REG_W) begin : g_bad_param
    $error("tsq_trigger_seq: unsupported parameter values");
  end

  typedef struct packed {
    tsq_pkg::tsq_clause_s [NUM_STATES-1:0][NUM_CLAUSES-1:0] prog;
    logic [NUM_WORDS-1:0][DATA_W-1:0] wval;
    logic [NUM_WORDS-1:0][DATA_W-1:0] wmask;
    logic mark_low;
    logic [tsq_pkg::POS_W-1:0] pos;
    logic [CW-1:0] post_def;
    logic store_qual;
    tsq_pkg::tsq_acq_e acq;
    logic trig;
    logic done;
    logic stopped;
    logic [SW-1:0] state;
    logic store_en;
    logic mark;
    logic [CW-1:0] post_left;
    logic [AW-1:0] wr_ptr;
    logic [CW-1:0] fill;
    logic [AW-1:0] trig_at;
    logic [tsq_pkg::IRQ_W-1:0] irq_stat;
    logic [tsq_pkg::IRQ_W-1:0] irq_mask;
    logic mem_wr;
    logic [AW-1:0] mem_addr;
    logic [DATA_W-1:0] mem_data;
    logic mem_trig;
    logic mem_stop;
    logic active;
    logic marker;
    logic irq;
    logic [tsq_pkg::REG_W-1:0] rdata;
  } tsq_regs_s;

  tsq_regs_s st_r;
  tsq_regs_s st_nxt;
  logic [tsq_pkg::EV_N-1:0] ev_src;
  logic [NUM_CLAUSES-1:0] hits;

  // Masked word compare: every cared-for bit must match
  function automatic logic word_match(input logic [DATA_W-1:0] d,
                                      input logic [DATA_W-1:0] v,
                                      input logic [DATA_W-1:0] m);
    return ((d ^ v) & m) == '0;
  endfunction

  // Program area hit for an address
  function automatic logic prog_sel(input logic [tsq_pkg::ADDR_W-1:0] a);
    return a[tsq_pkg::PA_AREA_BIT] && !a[tsq_pkg::PA_PAD_BIT] &&
           (int'(a[tsq_pkg::PA_ST_LSB +: SW]) < NUM_STATES) &&
           (int'(a[tsq_pkg::PA_CL_LSB +: CLW]) < NUM_CLAUSES);
  endfunction

  // Word recognizer register hit; msk selects the mask register
  function automatic logic word_reg(input logic [tsq_pkg::ADDR_W-1:0] a,
                                    input int w, input logic msk);
    return a == tsq_pkg::ADDR_W'(int'(tsq_pkg::A_WORD_BASE) + 2 * w + int'(msk));
  endfunction

  function automatic logic [tsq_pkg::REG_W-1:0] clause_word(
      input tsq_pkg::tsq_clause_s c, input logic [tsq_pkg::WD_IDX_W-1:0] w);
    case (w)
      tsq_pkg::CW_EVENTS: return {c.negate, c.join_or, c.ev_sel};
      tsq_pkg::CW_ACT_LO: return c.act[3:0];
      tsq_pkg::CW_ACT_HI: return c.act[7:4];
      default: return tsq_pkg::REG_W'(c.ev_cnt);
    endcase
  endfunction

  function automatic logic [CW-1:0] post_target(input logic [tsq_pkg::POS_W-1:0] pos,
                                                input logic [CW-1:0] def);
    logic [3:0] steps;
    steps = (pos[3:0] > tsq_pkg::POS_STEPS) ? tsq_pkg::POS_STEPS : pos[3:0];
    if (pos[tsq_pkg::POS_DEFINED_BIT]) begin
      return def;
    end
    return CW'((MEM_DEPTH / int'(tsq_pkg::POS_STEPS)) * int'(tsq_pkg::POS_STEPS - steps));
  endfunction

  // Event sources: word recognizers, then the always-true event
  for (genvar w = 0; w < NUM_WORDS; w++) begin : g_word
    assign ev_src[w] = word_match(samp_data, st_r.wval[w], st_r.wmask[w]);
  end
  for (genvar e = NUM_WORDS; e < tsq_pkg::EV_N; e++) begin : g_fixed
    assign ev_src[e] = (tsq_pkg::EV_SEL_W'(e) == tsq_pkg::EV_ANY);
  end

  // One evaluator per clause of the active state, all in parallel
  for (genvar g = 0; g < NUM_CLAUSES; g++) begin : g_clause
    tsq_clause_if cif ();
    assign cif.ev = ev_src;
    assign cif.cfg = st_r.prog[st_r.state][g];
    assign hits[g] = cif.hit;
    tsq_clause_eval u_eval (
      .cl(cif.eval)
    );
  end

  always_comb begin
    logic do_trig;
    logic do_xfer;
    logic s_on;
    logic s_off;
    logic m_on;
    logic m_off;
    logic fire;
    logic store;
    logic running;
    logic [SW-1:0] xfer_to;
    logic [tsq_pkg::ACT_KIND_W-1:0] kind;
    logic [tsq_pkg::ACT_ARG_W-1:0] arg;
    logic [SW-1:0] pst;
    logic [CLW-1:0] pcl;
    do_trig = 1'b0;
    do_xfer = 1'b0;
    s_on = 1'b0;
    s_off = 1'b0;
    m_on = 1'b0;
    m_off = 1'b0;
    fire = 1'b0;
    store = 1'b0;
    xfer_to = st_r.state;
    kind = tsq_pkg::ACT_NONE;
    arg = '0;
    pst = reg_addr[tsq_pkg::PA_ST_LSB +: SW];
    pcl = reg_addr[tsq_pkg::PA_CL_LSB +: CLW];
    running = (st_r.acq == tsq_pkg::ACQ_PRE) ||
              (st_r.acq == tsq_pkg::ACQ_POST && st_r.post_left != '0);
    st_nxt = st_r;
    st_nxt.mem_wr = 1'b0;
    st_nxt.mem_trig = 1'b0;
    st_nxt.mem_stop = 1'b0;
    st_nxt.rdata = '0;

    // Clear first so an event in the same cycle still sets its bit
    if (reg_wr && reg_addr == tsq_pkg::A_IRQ_STAT) begin
      st_nxt.irq_stat = st_r.irq_stat & ~reg_wdata[tsq_pkg::IRQ_W-1:0];
    end

    // Lowest-numbered clause wins a competing state transfer
    for (int c = NUM_CLAUSES - 1; c >= 0; c--) begin
      if (hits[c]) begin
        for (int a = 0; a < tsq_pkg::ACT_N; a++) begin
          kind = st_r.prog[st_r.state][c].act[a][tsq_pkg::ACT_W-1 -: tsq_pkg::ACT_KIND_W];
          arg = st_r.prog[st_r.state][c].act[a][tsq_pkg::ACT_ARG_W-1:0];
          case (kind)
            tsq_pkg::ACT_TRIGGER: do_trig = 1'b1;
            tsq_pkg::ACT_STATE_TRANSFER: begin
              if (int'(arg) < NUM_STATES) begin
                do_xfer = 1'b1;
                xfer_to = SW'(arg);
              end
            end
            tsq_pkg::ACT_STORE_ON: s_on = 1'b1;
            tsq_pkg::ACT_STORE_OFF: s_off = 1'b1;
            tsq_pkg::ACT_MARK_ON: m_on = 1'b1;
            tsq_pkg::ACT_MARK_OFF: m_off = 1'b1;
            default: ;
          endcase
        end
      end
    end

    if (st_r.acq == tsq_pkg::ACQ_POST && st_r.post_left == '0) begin
      st_nxt.acq = tsq_pkg::ACQ_IDLE;
      st_nxt.done = 1'b1;
      st_nxt.irq_stat[tsq_pkg::IRQ_DONE] = 1'b1;
    end else if (running && samp_valid) begin
      fire = do_trig && (st_r.acq == tsq_pkg::ACQ_PRE);
      store = !st_r.store_qual || st_r.store_en || s_on || fire;
      if (do_xfer) begin
        st_nxt.state = xfer_to;
      end
      if (s_on) begin
        st_nxt.store_en = 1'b1;
      end else if (s_off) begin
        st_nxt.store_en = 1'b0;
      end
      if (m_on) begin
        st_nxt.mark = 1'b1;
      end else if (m_off) begin
        st_nxt.mark = 1'b0;
      end
      if (store) begin
        st_nxt.mem_wr = 1'b1;
        st_nxt.mem_addr = st_r.wr_ptr;
        st_nxt.mem_data = samp_data;
        st_nxt.wr_ptr = AW'(st_r.wr_ptr + 1'b1);
        if (st_r.fill != CW'(MEM_DEPTH)) begin
          st_nxt.fill = CW'(st_r.fill + 1'b1);
        end
      end
      if (fire) begin
        st_nxt.acq = tsq_pkg::ACQ_POST;
        st_nxt.trig = 1'b1;
        st_nxt.trig_at = st_r.wr_ptr;
        st_nxt.mem_trig = 1'b1;
        st_nxt.post_left = post_target(st_r.pos, st_r.post_def);
        st_nxt.irq_stat[tsq_pkg::IRQ_TRIG] = 1'b1;
      end else if (st_r.acq == tsq_pkg::ACQ_POST && store) begin
        st_nxt.post_left = CW'(st_r.post_left - 1'b1);
      end
    end

    if (reg_wr) begin
      if (prog_sel(reg_addr)) begin
        case (reg_addr[tsq_pkg::PA_WD_LSB +: tsq_pkg::WD_IDX_W])
          tsq_pkg::CW_EVENTS: begin
            {st_nxt.prog[pst][pcl].negate, st_nxt.prog[pst][pcl].join_or,
             st_nxt.prog[pst][pcl].ev_sel} = reg_wdata;
          end
          tsq_pkg::CW_ACT_LO: st_nxt.prog[pst][pcl].act[3:0] = reg_wdata;
          tsq_pkg::CW_ACT_HI: st_nxt.prog[pst][pcl].act[7:4] = reg_wdata;
          default: st_nxt.prog[pst][pcl].ev_cnt = reg_wdata[tsq_pkg::EV_CNT_W-1:0];
        endcase
      end else begin
        case (reg_addr)
          tsq_pkg::A_CTRL: begin
            st_nxt.mark_low = reg_wdata[tsq_pkg::CTRL_MARK_LOW];
            if (reg_wdata[tsq_pkg::CTRL_DEFAULT]) begin
              // Position, storage mode and recognizers are left alone
              st_nxt.prog = '0;
              st_nxt.prog[0][0] = tsq_pkg::DEF_CLAUSE;
            end
            if (reg_wdata[tsq_pkg::CTRL_START]) begin
              st_nxt.acq = tsq_pkg::ACQ_PRE;
              st_nxt.state = '0;
              st_nxt.trig = 1'b0;
              st_nxt.done = 1'b0;
              st_nxt.stopped = 1'b0;
              st_nxt.store_en = 1'b0;
              st_nxt.mark = 1'b0;
              st_nxt.post_left = '0;
              st_nxt.wr_ptr = '0;
              st_nxt.fill = '0;
              st_nxt.trig_at = '0;
            end else if (reg_wdata[tsq_pkg::CTRL_STOP] &&
                         st_r.acq != tsq_pkg::ACQ_IDLE) begin
              st_nxt.acq = tsq_pkg::ACQ_IDLE;
              st_nxt.done = 1'b1;
              st_nxt.stopped = 1'b1;
              st_nxt.irq_stat[tsq_pkg::IRQ_DONE] = 1'b1;
              if (!st_r.trig) begin
                st_nxt.trig = 1'b1;
                st_nxt.trig_at = AW'(st_nxt.wr_ptr - 1'b1);
                st_nxt.mem_stop = 1'b1;
              end
            end
          end
          tsq_pkg::A_POS: st_nxt.pos = reg_wdata[tsq_pkg::POS_W-1:0];
          tsq_pkg::A_POST: st_nxt.post_def = reg_wdata[CW-1:0];
          tsq_pkg::A_STORE: st_nxt.store_qual = reg_wdata[tsq_pkg::STORE_QUAL_BIT];
          tsq_pkg::A_IRQ_MASK: st_nxt.irq_mask = reg_wdata[tsq_pkg::IRQ_W-1:0];
          default: begin
            for (int w = 0; w < NUM_WORDS; w++) begin
              if (word_reg(reg_addr, w, 1'b0)) begin
                st_nxt.wval[w] = reg_wdata[DATA_W-1:0];
              end
              if (word_reg(reg_addr, w, 1'b1)) begin
                st_nxt.wmask[w] = reg_wdata[DATA_W-1:0];
              end
            end
          end
        endcase
      end
    end

    if (reg_rd) begin
      if (prog_sel(reg_addr)) begin
        st_nxt.rdata = clause_word(st_r.prog[pst][pcl],
                                   reg_addr[tsq_pkg::PA_WD_LSB +: tsq_pkg::WD_IDX_W]);
      end else begin
        case (reg_addr)
          tsq_pkg::A_CTRL: st_nxt.rdata[tsq_pkg::CTRL_MARK_LOW] = st_r.mark_low;
          tsq_pkg::A_POS: st_nxt.rdata[tsq_pkg::POS_W-1:0] = st_r.pos;
          tsq_pkg::A_POST: st_nxt.rdata[CW-1:0] = st_r.post_def;
          tsq_pkg::A_STORE: st_nxt.rdata[tsq_pkg::STORE_QUAL_BIT] = st_r.store_qual;
          tsq_pkg::A_STATUS: begin
            st_nxt.rdata[tsq_pkg::ST_RUN] = st_r.active;
            st_nxt.rdata[tsq_pkg::ST_TRIG] = st_r.trig;
            st_nxt.rdata[tsq_pkg::ST_DONE] = st_r.done;
            st_nxt.rdata[tsq_pkg::ST_STOP] = st_r.stopped;
            st_nxt.rdata[tsq_pkg::ST_STATE_LSB +: SW] = st_r.state;
          end
          tsq_pkg::A_IRQ_STAT: st_nxt.rdata[tsq_pkg::IRQ_W-1:0] = st_r.irq_stat;
          tsq_pkg::A_IRQ_MASK: st_nxt.rdata[tsq_pkg::IRQ_W-1:0] = st_r.irq_mask;
          tsq_pkg::A_TRIG_AT: st_nxt.rdata[AW-1:0] = st_r.trig_at;
          tsq_pkg::A_FILL: st_nxt.rdata[CW-1:0] = st_r.fill;
          default: begin
            for (int w = 0; w < NUM_WORDS; w++) begin
              if (word_reg(reg_addr, w, 1'b0)) begin
                st_nxt.rdata[DATA_W-1:0] = st_r.wval[w];
              end
              if (word_reg(reg_addr, w, 1'b1)) begin
                st_nxt.rdata[DATA_W-1:0] = st_r.wmask[w];
              end
            end
          end
        endcase
      end
    end

    st_nxt.active = (st_nxt.acq != tsq_pkg::ACQ_IDLE);
    st_nxt.marker = st_nxt.mark ^ st_nxt.mark_low;
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
      st_r.prog[0][0] <= tsq_pkg::DEF_CLAUSE;
      st_r.pos <= tsq_pkg::POS_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign mem_wr = st_r.mem_wr;
  assign mem_addr = st_r.mem_addr;
  assign mem_data = st_r.mem_data;
  assign mem_trig = st_r.mem_trig;
  assign mem_stop = st_r.mem_stop;
  assign acq_active = st_r.active;
  assign marker_out = st_r.marker;
  assign irq = st_r.irq;
endmodule

// File: pkg/tsq_clause_if.sv
/*
  Link between the sequencer and one clause evaluator: event sources and
  clause program in, clause result out.
  Assumes both ends run combinationally on the sequencer's clock.
*/
`timescale 1ns/1ps
interface tsq_clause_if;
  logic [tsq_pkg::EV_N-1:0] ev;
  tsq_pkg::tsq_clause_s cfg;
  logic hit;
  modport eval (input ev, input cfg, output hit);
  modport seq (output ev, output cfg, input hit);
endinterface

// File: pkg/tsq_pkg.sv
/*
  Shared constants and types of the trigger state sequencer: register
  word indices, field positions, event and action codes, clause layout.
  Assumes a word-addressed register port with 32-bit data.
*/
package tsq_pkg;
  localparam int ADDR_W = 11;
  localparam int REG_W = 32;

  // Register word indices
  localparam logic [ADDR_W-1:0] A_CTRL = 11'h000;
  localparam logic [ADDR_W-1:0] A_POS = 11'h001;
  localparam logic [ADDR_W-1:0] A_POST = 11'h002;
  localparam logic [ADDR_W-1:0] A_STORE = 11'h003;
  localparam logic [ADDR_W-1:0] A_STATUS = 11'h004;
  localparam logic [ADDR_W-1:0] A_IRQ_STAT = 11'h005;
  localparam logic [ADDR_W-1:0] A_IRQ_MASK = 11'h006;
  localparam logic [ADDR_W-1:0] A_TRIG_AT = 11'h007;
  localparam logic [ADDR_W-1:0] A_FILL = 11'h008;
  localparam logic [ADDR_W-1:0] A_WORD_BASE = 11'h010;

  // Program area: {1, 0, state[3:0], clause[2:0], word[1:0]}
  localparam int PA_AREA_BIT = 10;
  localparam int PA_PAD_BIT = 9;
  localparam int PA_ST_LSB = 5;
  localparam int PA_CL_LSB = 2;
  localparam int PA_WD_LSB = 0;
  localparam int ST_IDX_W = 4;
  localparam int CL_IDX_W = 3;
  localparam int WD_IDX_W = 2;
  localparam logic [WD_IDX_W-1:0] CW_EVENTS = 2'h0;
  localparam logic [WD_IDX_W-1:0] CW_ACT_LO = 2'h1;
  localparam logic [WD_IDX_W-1:0] CW_ACT_HI = 2'h2;
  localparam logic [WD_IDX_W-1:0] CW_COUNT = 2'h3;

  // Field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_DEFAULT = 2;
  localparam int CTRL_MARK_LOW = 3;
  localparam int POS_W = 5;
  localparam int POS_DEFINED_BIT = 4;
  localparam logic [3:0] POS_STEPS = 4'h8;
  localparam logic [POS_W-1:0] POS_RESET = 5'h04;
  localparam int STORE_QUAL_BIT = 0;
  localparam int ST_RUN = 0;
  localparam int ST_TRIG = 1;
  localparam int ST_DONE = 2;
  localparam int ST_STOP = 3;
  localparam int ST_STATE_LSB = 4;
  localparam int IRQ_W = 2;
  localparam int IRQ_TRIG = 0;
  localparam int IRQ_DONE = 1;

  // Clause layout
  localparam int EV_N = 8;
  localparam int EV_SEL_W = 3;
  localparam int EV_CNT_W = 4;
  localparam int ACT_N = 8;
  localparam int ACT_W = 8;
  localparam int ACT_KIND_W = 4;
  localparam int ACT_ARG_W = 4;
  localparam logic [EV_SEL_W-1:0] EV_WORD0 = 3'h0;
  localparam logic [EV_SEL_W-1:0] EV_ANY = 3'h4;
  localparam logic [ACT_KIND_W-1:0] ACT_NONE = 4'h0;
  localparam logic [ACT_KIND_W-1:0] ACT_TRIGGER = 4'h1;
  localparam logic [ACT_KIND_W-1:0] ACT_STATE_TRANSFER = 4'h2;
  localparam logic [ACT_KIND_W-1:0] ACT_STORE_ON = 4'h3;
  localparam logic [ACT_KIND_W-1:0] ACT_STORE_OFF = 4'h4;
  localparam logic [ACT_KIND_W-1:0] ACT_MARK_ON = 4'h5;
  localparam logic [ACT_KIND_W-1:0] ACT_MARK_OFF = 4'h6;

  typedef struct packed {
    logic [EV_CNT_W-1:0] ev_cnt;
    logic negate;
    logic [EV_N-2:0] join_or;
    logic [EV_N-1:0][EV_SEL_W-1:0] ev_sel;
    logic [ACT_N-1:0][ACT_W-1:0] act;
  } tsq_clause_s;

  // One event on word recognizer 0, one trigger action
  localparam tsq_clause_s DEF_CLAUSE = '{
    ev_cnt: 4'h1,
    negate: 1'b0,
    join_or: '0,
    ev_sel: {EV_N{EV_WORD0}},
    act: {{(ACT_N-1){8'h00}}, ACT_TRIGGER, 4'h0}
  };

  typedef enum logic [1:0] {ACQ_IDLE, ACQ_PRE, ACQ_POST} tsq_acq_e;
endpackage

// File: tb/testbench.sv
/*
  Testbench of the trigger sequencer: register and sample tasks, tests
  as call sequences with expected values. Assumes a 64-word memory.
*/
`timescale 1ns/1ps
module testbench;
  localparam int DEPTH = 64;
  logic sys_clk;
  logic rstn;
  logic [10:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic samp_valid;
  logic [31:0] samp_data;
  logic mem_wr;
  logic [5:0] mem_addr;
  logic [31:0] mem_data;
  logic mem_trig;
  logic mem_stop;
  logic acq_active;
  logic marker_out;
  logic irq;
  int err_count;
  int check_count;
  int w0;
  int t0;
  int s0;
  logic [31:0] rv;
  logic [31:0] wv [3] = '{32'ha5, 32'h11, 32'h22};
  tsq_trigger_seq #(.MEM_DEPTH(DEPTH)) i_tsq_trigger_seq (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .samp_valid(samp_valid),
    .samp_data(samp_data), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_data(mem_data),
    .mem_trig(mem_trig), .mem_stop(mem_stop), .acq_active(acq_active),
    .marker_out(marker_out), .irq(irq));
  tsq_mem_model #(.DEPTH(DEPTH), .DW(32)) i_tsq_mem_model (
    .sys_clk(sys_clk), .rstn(rstn), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_data(mem_data), .mem_trig(mem_trig), .mem_stop(mem_stop));
  task automatic print_verdict();
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdchk(input string n, input logic [10:0] a, input logic [31:0] e,
                       input logic [31:0] m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    chk(n, e, reg_rdata & m);
  endtask
  task automatic samp(input logic [31:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      samp_valid <= 1'b1;
      samp_data <= d;
      @(posedge sys_clk);
    end
    samp_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic start();
    w0 = i_tsq_mem_model.wr_cnt;
    t0 = i_tsq_mem_model.trig_cnt;
    s0 = i_tsq_mem_model.stop_cnt;
    wr(tsq_pkg::A_CTRL, 32'h1);
  endtask
  task automatic words();
    for (int i = 0; i < 3; i++) begin
      wr(11'(16 + 2 * i), wv[i]);
      wr(11'(17 + 2 * i), 32'hff);
    end
  endtask
  function automatic logic [10:0] pa(input int st, input int cl, input int w);
    return 11'(1024 + st * 32 + cl * 4 + w);
  endfunction
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // About 140 cycles of tests; 20000 cycles means a hang
  initial begin
    #200000;
    err_count++;
    print_verdict();
  end
  initial begin
    rstn = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    samp_valid = 1'b0;
    samp_data = '0;
    err_count = 0;
    check_count = 0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rdchk("pos", tsq_pkg::A_POS, 32'h4, '1);
    rdchk("unmapped", 11'h00f, 32'h0, '1);
    // Word0 moves to state 5, where not (word1 or word2) triggers
    words();
    wr(pa(0, 0, 1), 32'h25);
    wr(pa(5, 0, 0), 32'h8100_0011);
    wr(pa(5, 0, 1), 32'h10);
    wr(pa(5, 0, 3), 32'h2);
    wr(tsq_pkg::A_POS, 32'h7);
    start();
    samp(32'h11, 1);
    samp(32'ha5, 1);
    rdchk("status", tsq_pkg::A_STATUS, 32'h51, '1);
    samp(32'h11, 1);
    samp(32'h22, 1);
    samp(32'h33, 10);
    rdchk("trig_at", tsq_pkg::A_TRIG_AT, 32'h4, '1);
    rdchk("fill", tsq_pkg::A_FILL, 32'hd, '1);
    chk("trig marks", 1, i_tsq_mem_model.trig_cnt - t0);
    rdchk("status", tsq_pkg::A_STATUS, 32'h6, 32'hf);
    // Interrupt raised, masked and cleared
    rdchk("irq_stat", tsq_pkg::A_IRQ_STAT, 32'h3, '1);
    chk("irq", 0, irq);
    wr(tsq_pkg::A_IRQ_MASK, 32'h2);
    @(posedge sys_clk);
    chk("irq", 1, irq);
    wr(tsq_pkg::A_IRQ_STAT, 32'h2);
    @(posedge sys_clk);
    chk("irq", 0, irq);
    // Default program keeps position and storage mode
    wr(tsq_pkg::A_STORE, 32'h1);
    wr(tsq_pkg::A_POS, 32'h10);
    wr(tsq_pkg::A_POST, 32'h3);
    wr(tsq_pkg::A_CTRL, 32'h4);
    rdchk("pos", tsq_pkg::A_POS, 32'h10, '1);
    rdchk("store", tsq_pkg::A_STORE, 32'h1, '1);
    wr(tsq_pkg::A_STORE, 32'h0);
    words();
    start();
    samp(32'h1, 3);
    samp(32'ha5, 1);
    samp(32'h2, 4);
    rdchk("trig_at", tsq_pkg::A_TRIG_AT, 32'h3, '1);
    chk("writes", 7, i_tsq_mem_model.wr_cnt - w0);
    // Stop before the trigger
    wr(tsq_pkg::A_POS, 32'h4);
    start();
    samp(32'h1, 5);
    wr(tsq_pkg::A_CTRL, 32'h2);
    // The model counts the stop mark one edge after the pulse
    @(posedge sys_clk);
    chk("stop marks", 1, i_tsq_mem_model.stop_cnt - s0);
    rdchk("trig_at", tsq_pkg::A_TRIG_AT, 32'h4, '1);
    rdchk("status", tsq_pkg::A_STATUS, 32'he, 32'hf);
    chk("trig marks", 0, i_tsq_mem_model.trig_cnt - t0);
    // Marker polarity
    wr(tsq_pkg::A_CTRL, 32'h8);
    @(posedge sys_clk);
    chk("marker", 1, marker_out);
    wr(tsq_pkg::A_CTRL, 32'h0);
    @(posedge sys_clk);
    chk("marker", 0, marker_out);
    print_verdict();
  end
endmodule

// File: tb/tsq_assertions.sv
/*
  Checker of the trigger sequencer's memory-side ports.
  Assumes it is bound to tsq_trigger_seq and sees only its ports.
*/
`timescale 1ns/1ps
module tsq_assertions #(
  parameter int DATA_W = 32,
  parameter int MEM_DEPTH = 8192
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register port
  input wire logic [tsq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [tsq_pkg::REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [tsq_pkg::REG_W-1:0] reg_rdata,
  // Sample stream
  input wire logic samp_valid,
  input wire logic [DATA_W-1:0] samp_data,
  // Acquisition memory
  input wire logic mem_wr,
  input wire logic [$clog2(MEM_DEPTH)-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_data,
  input wire logic mem_trig,
  input wire logic mem_stop,
  // Status
  input wire logic acq_active,
  input wire logic marker_out,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic trig_seen_r;
  logic have_wr_r;
  logic [$clog2(MEM_DEPTH)-1:0] last_addr_r;
  // Per-acquisition history: flags cleared while idle, last_addr_r kept
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      trig_seen_r <= 1'b0;
      have_wr_r <= 1'b0;
      last_addr_r <= '0;
    end else begin
      trig_seen_r <= acq_active && (trig_seen_r || mem_trig);
      have_wr_r <= acq_active && (have_wr_r || mem_wr);
      if (mem_wr) begin
        last_addr_r <= mem_addr;
      end
    end
  end
  property p_trig_wr;
    mem_trig |-> mem_wr;
  endproperty
  a_trig_wr: assert property (p_trig_wr) else $error("trigger mark without write");
  property p_one_trig;
    mem_trig |-> !trig_seen_r;
  endproperty
  a_one_trig: assert property (p_one_trig) else $error("second trigger in one run");
  property p_wr_active;
    mem_wr |-> acq_active;
  endproperty
  a_wr_active: assert property (p_wr_active) else $error("write while idle");
  property p_wr_data;
    mem_wr |-> $past(samp_valid) && mem_data == $past(samp_data);
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("stored word is not the sample");
  property p_addr_first;
    mem_wr && !have_wr_r |-> mem_addr == '0;
  endproperty
  a_addr_first: assert property (p_addr_first) else $error("run not started at 0");
  property p_addr_next;
    mem_wr && have_wr_r |-> mem_addr == last_addr_r + 1'b1;
  endproperty
  a_addr_next: assert property (p_addr_next) else $error("write address skipped");
  property p_stop_end;
    mem_stop |-> ##[0:1] !acq_active;
  endproperty
  a_stop_end: assert property (p_stop_end) else $error("run goes on after stop");
  property p_stop_quiet;
    mem_stop |=> !mem_wr [*2];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet) else $error("write after stop");
endmodule
bind tsq_trigger_seq tsq_assertions #(.DATA_W(DATA_W), .MEM_DEPTH(MEM_DEPTH)) i_tsq_assertions (
  .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .samp_valid(samp_valid),
  .samp_data(samp_data), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_data(mem_data),
  .mem_trig(mem_trig), .mem_stop(mem_stop), .acq_active(acq_active),
  .marker_out(marker_out), .irq(irq));

// File: tb/tsq_mem_model.sv
/*
  Acquisition memory model: keeps stored words and counts writes,
  trigger marks and stop marks. Assumes the sequencer's write port.
*/
`timescale 1ns/1ps
module tsq_mem_model #(
  parameter int DEPTH = 64,
  parameter int DW = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Write port
  input wire logic mem_wr,
  input wire logic [$clog2(DEPTH)-1:0] mem_addr,
  input wire logic [DW-1:0] mem_data,
  input wire logic mem_trig,
  input wire logic mem_stop
);
  logic [DW-1:0] mem [DEPTH];
  int wr_cnt;
  int trig_cnt;
  int stop_cnt;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_cnt <= 0;
      trig_cnt <= 0;
      stop_cnt <= 0;
    end else begin
      if (mem_wr) begin
        mem[mem_addr] <= mem_data;
        wr_cnt <= wr_cnt + 1;
      end
      if (mem_trig) begin
        trig_cnt <= trig_cnt + 1;
      end
      if (mem_stop) begin
        stop_cnt <= stop_cnt + 1;
      end
    end
  end
endmodule
